//--- rtl/icau_pkg.sv
package icau_pkg;

  // Datapath widths
  localparam int XLEN = 32;
  localparam int IMM_W = 16;
  localparam int PROD_W = 48;
  localparam int CNT_W_DEF = 32;

  // Register port
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_EXC = 4'h0;
  localparam logic [ADDR_W-1:0] REG_COND = 4'h4;
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'hc;

  // Integer exception register bit positions
  localparam int EXC_SO_BIT = 31;
  localparam int EXC_OVF_BIT = 30;
  localparam int EXC_CARRY_BIT = 29;

  // First condition field bit positions (field bit 3, LT, is the MSB)
  localparam int COND_W = 4;
  localparam int COND_LT_BIT = 3;
  localparam int COND_GT_BIT = 2;
  localparam int COND_EQ_BIT = 1;
  localparam int COND_SO_BIT = 0;

  // Constants and reset values
  localparam logic [XLEN-1:0] ALL_ONES = 32'hffffffff;
  localparam logic [XLEN-1:0] ZERO_WORD = 32'h00000000;
  localparam logic [COND_W-1:0] COND_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam int DEST_W = 5;

  // Operation codes from the sequencer
  typedef enum logic [3:0] {
    OP_SUBFC = 4'h0,
    OP_ADDE = 4'h1,
    OP_SUBFE = 4'h2,
    OP_ADDME = 4'h3,
    OP_SUBFME = 4'h4,
    OP_ADDZE = 4'h5,
    OP_SUBFZE = 4'h6,
    OP_NEG = 4'h7,
    OP_MULLI = 4'h8
  } icau_op_t;

endpackage : icau_pkg

//--- rtl/icau_res_if.sv
`timescale 1ns/1ps
interface icau_res_if #(parameter int W = 32);
  logic [W-1:0] res;
  logic carry;
  logic ovf;
  // Arithmetic leaf drives, top consumes
  modport src (output res, output carry, output ovf);
  modport dst (input res, input carry, input ovf);
endinterface : icau_res_if

//--- rtl/icau_adder.sv
`timescale 1ns/1ps
module icau_adder
  import icau_pkg::*;
#(
  parameter int W = XLEN
) (
  // Prepared operands
  input wire logic [W-1:0] opX,
  input wire logic [W-1:0] opY,
  input wire logic carryIn,
  // Result
  icau_res_if.src out
);

  logic [W:0] sumWide;

  // Sum modulo 2^W with carry out and signed overflow
  always_comb begin
    sumWide = {1'b0, opX} + {1'b0, opY} + {{W{1'b0}}, carryIn};
    out.res = sumWide[W-1:0];
    out.carry = sumWide[W];
    out.ovf = (opX[W-1] == opY[W-1]) && (sumWide[W-1] != opX[W-1]);
  end

endmodule : icau_adder

//--- rtl/icau_mul.sv
`timescale 1ns/1ps
module icau_mul
  import icau_pkg::*;
#(
  parameter int W = XLEN,
  parameter int IW = IMM_W
) (
  // Operands
  input wire logic [W-1:0] firstSource,
  input wire logic [IW-1:0] signedImmediate,
  // Result
  icau_res_if.src out
);

  logic signed [W+IW-1:0] product;

  // Signed product; only the low word is kept
  always_comb begin
    product = $signed(firstSource) * $signed(signedImmediate);
    out.res = product[W-1:0];
    // Overflow when the product does not fit a signed word
    out.ovf = !((&product[W+IW-1:W-1]) || !(|product[W+IW-1:W-1]));
    out.carry = 1'b0;
  end

endmodule : icau_mul

//--- rtl/icau_arith_unit.sv
`timescale 1ns/1ps
module icau_arith_unit
  import icau_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Sequencer request
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic recordEn,
  input wire logic overflowEn,
  input wire logic [DEST_W-1:0] destIdx,
  input wire logic [XLEN-1:0] firstSourceRegister,
  input wire logic [XLEN-1:0] secondSourceRegister,
  input wire logic [IMM_W-1:0] signedImmediate,
  // Register file write-back
  output logic resValid,
  output logic [DEST_W-1:0] resDest,
  output logic [XLEN-1:0] resData,
  // Flag state
  output logic carryFlag,
  output logic overflowFlag,
  output logic summaryOverflowFlag,
  output logic [COND_W-1:0] firstConditionField,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [XLEN-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [XLEN-1:0] regRdData
);

  // Condition field from a result, signed compare against zero
  function automatic logic [COND_W-1:0] condOf(input logic [XLEN-1:0] val, input logic so);
    logic [COND_W-1:0] f;
    f = COND_RESET;
    f[COND_LT_BIT] = val[XLEN-1];
    f[COND_GT_BIT] = !val[XLEN-1] && (val != ZERO_WORD);
    f[COND_EQ_BIT] = (val == ZERO_WORD);
    f[COND_SO_BIT] = so;
    return f;
  endfunction : condOf

  // Registered state
  logic resValid_r;
  logic [DEST_W-1:0] resDest_r;
  logic [XLEN-1:0] resData_r;
  logic carry_r;
  logic ovf_r;
  logic so_r;
  logic [COND_W-1:0] cond_r;
  logic [CNT_W-1:0] opCount_r;
  logic [XLEN-1:0] regRdData_r;

  // Operand preparation
  logic [XLEN-1:0] opX;
  logic [XLEN-1:0] opY;
  logic carryIn;
  logic writesCarry;
  logic isMul;
  logic knownOp;
  logic accept;

  // Selected result
  logic [XLEN-1:0] result;
  logic resOvf;
  logic resCarry;
  logic so_nxt;
  logic ovf_nxt;
  logic carry_nxt;

  // Software writes to the exception register
  logic excWrite;
  logic [XLEN-1:0] excView;

  icau_res_if #(.W(XLEN)) addBus ();
  icau_res_if #(.W(XLEN)) mulBus ();

  // Operand steering per operation
  always_comb begin
    opX = firstSourceRegister;
    opY = ZERO_WORD;
    carryIn = 1'b0;
    writesCarry = 1'b1;
    isMul = 1'b0;
    knownOp = 1'b1;
    case (icau_op_t'(opCode))
      OP_SUBFC: begin
        opX = ~firstSourceRegister;
        opY = secondSourceRegister;
        carryIn = 1'b1;
      end
      OP_ADDE: begin
        opY = secondSourceRegister;
        carryIn = carry_r;
      end
      OP_SUBFE: begin
        opX = ~firstSourceRegister;
        opY = secondSourceRegister;
        carryIn = carry_r;
      end
      OP_ADDME: begin
        opY = ALL_ONES;
        carryIn = carry_r;
      end
      OP_SUBFME: begin
        opX = ~firstSourceRegister;
        opY = ALL_ONES;
        carryIn = carry_r;
      end
      OP_ADDZE: begin
        carryIn = carry_r;
      end
      OP_SUBFZE: begin
        opX = ~firstSourceRegister;
        carryIn = carry_r;
      end
      OP_NEG: begin
        opX = ~firstSourceRegister;
        carryIn = 1'b1;
        writesCarry = 1'b0;
      end
      OP_MULLI: begin
        isMul = 1'b1;
        writesCarry = 1'b0;
      end
      default: begin
        knownOp = 1'b0;
        writesCarry = 1'b0;
      end
    endcase
  end

  icau_adder #(.W(XLEN)) uAdder (
    .opX(opX),
    .opY(opY),
    .carryIn(carryIn),
    .out(addBus.src)
  );

  icau_mul #(.W(XLEN), .IW(IMM_W)) uMul (
    .firstSource(firstSourceRegister),
    .signedImmediate(signedImmediate),
    .out(mulBus.src)
  );

  assign accept = clkEn && opValid && knownOp;
  assign excWrite = clkEn && regWrStb && (regAddr == REG_EXC);

  // Result and flag selection
  always_comb begin
    result = isMul ? mulBus.res : addBus.res;
    resOvf = isMul ? mulBus.ovf : addBus.ovf;
    resCarry = addBus.carry;
  end

  // Next flag values; an operation beats a software write on carry and overflow, summary overflow ORs the written bit with the result overflow
  always_comb begin
    carry_nxt = carry_r;
    ovf_nxt = ovf_r;
    so_nxt = so_r;
    if (excWrite) begin
      carry_nxt = regWrData[EXC_CARRY_BIT];
      ovf_nxt = regWrData[EXC_OVF_BIT];
      so_nxt = regWrData[EXC_SO_BIT];
    end
    if (accept && writesCarry) begin
      carry_nxt = resCarry;
    end
    if (accept && overflowEn) begin
      ovf_nxt = resOvf;
      so_nxt = so_nxt || resOvf;
    end
  end

  // Write-back to the register file
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resValid_r <= 1'b0;
      resDest_r <= '0;
      resData_r <= ZERO_WORD;
    end else if (clkEn) begin
      resValid_r <= accept;
      if (accept) begin
        resDest_r <= destIdx;
        resData_r <= result;
      end
    end
  end

  // Exception register flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      carry_r <= FLAG_RESET;
      ovf_r <= FLAG_RESET;
      so_r <= FLAG_RESET;
    end else if (clkEn) begin
      carry_r <= carry_nxt;
      ovf_r <= ovf_nxt;
      so_r <= so_nxt;
    end
  end

  // First condition field on record variants
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cond_r <= COND_RESET;
    end else if (clkEn && accept && recordEn) begin
      cond_r <= condOf(result, so_nxt);
    end
  end

  // Completed operation counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opCount_r <= '0;
    end else if (clkEn && accept) begin
      opCount_r <= opCount_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Exception register as software sees it
  always_comb begin
    excView = ZERO_WORD;
    excView[EXC_SO_BIT] = so_r;
    excView[EXC_OVF_BIT] = ovf_r;
    excView[EXC_CARRY_BIT] = carry_r;
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_r <= ZERO_WORD;
    end else if (clkEn) begin
      if (!regRdStb) begin
        regRdData_r <= ZERO_WORD;
      end else if (regAddr == REG_EXC) begin
        regRdData_r <= excView;
      end else if (regAddr == REG_COND) begin
        regRdData_r <= {{(XLEN-COND_W){1'b0}}, cond_r};
      end else if (regAddr == REG_RESULT) begin
        regRdData_r <= resData_r;
      end else if (regAddr == REG_COUNT) begin
        regRdData_r <= XLEN'(opCount_r);
      end else begin
        regRdData_r <= ZERO_WORD;
      end
    end
  end

  // Outputs straight from flops
  assign resValid = resValid_r;
  assign resDest = resDest_r;
  assign resData = resData_r;
  assign carryFlag = carry_r;
  assign overflowFlag = ovf_r;
  assign summaryOverflowFlag = so_r;
  assign firstConditionField = cond_r;
  assign regRdData = regRdData_r;

endmodule : icau_arith_unit

//--- testbench/icau_gpr_model.sv
`timescale 1ns/1ps
module icau_gpr_model
  import icau_pkg::*;
(
  // Write-back from the unit
  input wire logic mclk,
  input wire logic resValid,
  input wire logic [DEST_W-1:0] resDest,
  input wire logic [XLEN-1:0] resData
);
  logic [XLEN-1:0] gpr [32];
  // Register file takes every result pulse
  always_ff @(posedge mclk) begin
    if (resValid) begin
      gpr[resDest] <= resData;
    end
  end
endmodule : icau_gpr_model

//--- testbench/icau_arith_unit_asserts.sv
`timescale 1ns/1ps
module icau_arith_unit_asserts
  import icau_pkg::*;
(
  // Watched ports
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic recordEn,
  input wire logic overflowEn,
  input wire logic regWrStb,
  input wire logic [XLEN-1:0] firstSourceRegister,
  input wire logic resValid,
  input wire logic [XLEN-1:0] resData,
  input wire logic carryFlag,
  input wire logic overflowFlag,
  input wire logic summaryOverflowFlag,
  input wire logic [COND_W-1:0] firstConditionField
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Accepted request, no software write beside it
  sequence accOp;
    clkEn && opValid && opCode <= 4'h8 && !regWrStb;
  endsequence
  sequence recOp;
    accOp ##0 recordEn;
  endsequence
  resp_pulse_a: assert property (accOp |=> resValid) else $error("no result");
  no_resp_a:
    assert property (clkEn && !(opValid && opCode <= 4'h8) |=> !resValid)
    else $error("stray result");
  cond_hold_a:
    assert property (accOp ##0 !recordEn |=> $stable(firstConditionField))
    else $error("cond changed");
  ovf_hold_a:
    assert property (accOp ##0 !overflowEn |=> $stable(overflowFlag))
    else $error("ovf changed");
  carry_hold_a:
    assert property (accOp ##0 opCode >= 4'h7 |=> $stable(carryFlag))
    else $error("carry changed");
  cond_sign_a:
    assert property (recOp |=> firstConditionField[3:1] ==
    {resData[31], !resData[31] && resData != 32'h0, resData == 32'h0})
    else $error("cond sign");
  cond_so_a:
    assert property (recOp |=> firstConditionField[0] == summaryOverflowFlag)
    else $error("cond summary");
  ovf_sum_a:
    assert property (accOp ##0 overflowEn |=> !overflowFlag || summaryOverflowFlag)
    else $error("summary not set");
  so_sticky_a:
    assert property (summaryOverflowFlag && !regWrStb |=> summaryOverflowFlag)
    else $error("summary lost");
  neg_value_a:
    assert property (accOp ##0 opCode == 4'h7 |=>
    resData == ~$past(firstSourceRegister) + 32'h1) else $error("negate");
endmodule : icau_arith_unit_asserts

bind icau_arith_unit icau_arith_unit_asserts u_asserts (.mclk, .rst_n, .clkEn, .opValid,
  .opCode, .recordEn, .overflowEn, .regWrStb, .firstSourceRegister, .resValid, .resData,
  .carryFlag, .overflowFlag, .summaryOverflowFlag, .firstConditionField);

//--- testbench/icau_arith_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module icau_arith_unit_tb_top
  import icau_pkg::*;
;
  logic mclk = 0, rst_n = 0, clkEn = 1, opValid = 0, recordEn = 0, overflowEn = 0;
  logic regWrStb = 0, regRdStb = 0, cy = 0;
  logic [3:0] opCode = 4'h0, regAddr = 4'h0;
  logic [DEST_W-1:0] destIdx = 5'h0;
  logic [XLEN-1:0] srcA = 32'h0, srcB = 32'h0, regWrData = 32'h0, a;
  logic [IMM_W-1:0] imm = 16'hfffe;
  logic [32:0] expV;
  logic resValid, carryFlag, overflowFlag, summaryOverflowFlag;
  logic [DEST_W-1:0] resDest;
  logic [XLEN-1:0] resData, regRdData;
  logic [COND_W-1:0] firstConditionField;
  int errorCnt = 0, samplesChecked = 0, cycles = 0;
  icau_arith_unit u_icau_arith_unit (.mclk, .rst_n, .clkEn, .opValid, .opCode, .recordEn,
    .overflowEn, .destIdx, .firstSourceRegister(srcA), .secondSourceRegister(srcB),
    .signedImmediate(imm), .resValid, .resDest, .resData, .carryFlag, .overflowFlag,
    .summaryOverflowFlag, .firstConditionField, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData);
  icau_gpr_model u_icau_gpr_model (.mclk, .resValid, .resDest, .resData);
  // Clock and hang guard
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      errorCnt++;
      tallyAndFinish();
    end
  end
  // Reference sums and product, carry out in the top bit (carry in for the product)
  function automatic logic [32:0] model(input logic [3:0] c, input logic [31:0] x, y,
    input logic ci);
    logic [32:0] na, pa, cc;
    logic signed [47:0] p;
    na = {1'b0, ~x};
    pa = {1'b0, x};
    cc = {32'h0, ci};
    p = $signed(x) * $signed(imm);
    case (c)
      4'h0: model = na + y + 33'h1;
      4'h1: model = pa + y + cc;
      4'h2: model = na + y + cc;
      4'h3: model = pa + cc + ALL_ONES;
      4'h4: model = na + cc + ALL_ONES;
      4'h5: model = pa + cc;
      4'h6: model = na + cc;
      4'h7: model = na + 33'h1;
      default: model = {ci, p[31:0]};
    endcase
  endfunction : model
  // One operation, result cycle left open for checks
  task op(input logic [3:0] c, input logic [31:0] x, input logic rec, ovf);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= c;
    srcA <= x;
    srcB <= 32'hffff0001;
    recordEn <= rec;
    overflowEn <= ovf;
    destIdx <= {1'b0, c} + 5'h1;
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask : op
  task wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge mclk);
    regWrStb <= 1'b1;
    regAddr <= ad;
    regWrData <= d;
    @(posedge mclk);
    regWrStb <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge mclk);
    regRdStb <= 1'b1;
    regAddr <= ad;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1;
    `CHK(regRdData, e)
  endtask : rd
  task tallyAndFinish();
    $display("mismatches %0d comparisons %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tallyAndFinish
  // Every operation code with two operand sets
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      a = (j == 0) ? 32'h80000000 : 32'h0000ffff;
      for (int k = 0; k < 9; k++) begin
        expV = model(k[3:0], a, 32'hffff0001, cy);
        op(k[3:0], a, k[0], k == 7);
        `CHK(resValid, 1'b1)
        `CHK(resData, expV[31:0])
        if (k < 7) cy = expV[32];
        `CHK(carryFlag, cy)
        // Register file takes the result one edge later
        @(posedge mclk);
        #1;
        `CHK(u_icau_gpr_model.gpr[k + 1], expV[31:0])
      end
    end
    `CHK(firstConditionField, 4'h9)
    rd(REG_EXC, {2'h2, cy, 29'h0});
    rd(REG_COUNT, 32'h00000012);
    op(4'h9, a, 1'b1, 1'b1);
    `CHK(resValid, 1'b0)
    clkEn <= 1'b0;
    op(4'h1, a, 1'b1, 1'b1);
    `CHK(resValid, 1'b0)
    clkEn <= 1'b1;
    wr(REG_RESULT, 32'h00001234);
    rd(REG_RESULT, expV[31:0]);
    wr(REG_EXC, 32'h0);
    rd(REG_EXC, 32'h0);
    rd(4'h1, 32'h0);
    tallyAndFinish();
  end
endmodule : icau_arith_unit_tb_top
